// [verilog/fbc_cmd.sv]
// command handler for the user storage area: erase, write, erase then write
// assumes request frames arrive as a byte stream on pclk with frame meta stable at byte 0
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "fbc_regs.svh"
module fbc_cmd import fbc_pkg::*; #(
   parameter int NUM_BLOCKS = 119,
   parameter int BLOCK_SIZE = 512,
   parameter int MAX_PAYLOAD = 256
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rq_valid,
   input wire logic [7:0] rq_data,
   input wire logic rq_last,
   input wire logic rq_unicast,
   input wire logic [7:0] rq_src_ep,
   input wire logic [7:0] rq_dst_ep,
   input wire logic [15:0] rq_cluster,
   output logic rq_ready,
   output logic rp_valid,
   output logic [7:0] rp_data,
   output logic rp_last,
   output logic [7:0] rp_dst_ep,
   input wire logic rp_ready
);
   localparam int TOTAL = NUM_BLOCKS * BLOCK_SIZE;
   localparam int AW = $clog2(TOTAL);
   // ****************************************
   // state
   // ****************************************
   fbc_state_t st_reg, st_next;
   fbc_hdr_t hdr_reg, hdr_next;
   logic [3:0] hidx_reg, hidx_next;
   logic reply_en_reg, reply_en_next;
   logic [7:0] ep_reg, ep_next;
   logic [7:0] status_reg, status_next;
   logic last_seen_reg, last_seen_next;
   logic [AW-1:0] ea_reg, ea_next, eend_reg, eend_next, base_reg, base_next;
   logic [15:0] wcnt_reg, wcnt_next;
   logic [2:0] rp_pos_reg, rp_pos_next;
   fbc_beat_t rp_reg, rp_next;
   logic rq_ready_next;
   logic mem_we;
   logic [AW-1:0] mem_waddr;
   logic [7:0] mem_wdata, peek_rdata;
   logic ctrl_en_reg, ctrl_en_next;
   logic [AW-1:0] peek_reg, peek_next;
   logic [31:0] count_reg, count_next, prdata_next;
   logic pready_next, pslverr_next;
   logic take;
   fbc_hdr_t h;
   assign take = rq_valid && rq_ready;

   function automatic logic [7:0] reply_byte(input fbc_hdr_t hh, input logic [7:0] stat,
                                             input logic [2:0] pos);
      unique case (pos)
         3'd0: reply_byte = hh.command_code | `FBC_REPLY_BIT;
         3'd1: reply_byte = stat;
         3'd2: reply_byte = hh.block_index[15:8];
         3'd3: reply_byte = hh.block_index[7:0];
         3'd4: reply_byte = hh.byte_offset_in_block[15:8];
         3'd5: reply_byte = hh.byte_offset_in_block[7:0];
         default: reply_byte = 8'h00;
      endcase
   endfunction

   // ****************************************
   // frame parsing and storage sequencing
   // ****************************************
   always_comb begin
      st_next = st_reg;
      hdr_next = hdr_reg;
      hidx_next = hidx_reg;
      reply_en_next = reply_en_reg;
      ep_next = ep_reg;
      status_next = status_reg;
      last_seen_next = last_seen_reg;
      ea_next = ea_reg;
      eend_next = eend_reg;
      base_next = base_reg;
      wcnt_next = wcnt_reg;
      rp_pos_next = rp_pos_reg;
      rp_next = rp_reg;
      count_next = count_reg;
      mem_we = 1'b0;
      mem_waddr = ea_reg;
      mem_wdata = `FBC_ERASED;
      h = fbc_hdr_t'({hdr_reg[55:0], rq_data});
      unique case (st_reg)
         FBC_IDLE, FBC_HDR: begin
            if (take) begin
               hdr_next = h;
               hidx_next = hidx_reg + 4'd1;
               last_seen_next = rq_last;
               status_next = `FBC_OK;
               wcnt_next = 16'h0000;
               st_next = FBC_HDR;
               if (st_reg == FBC_IDLE) begin
                  hidx_next = 4'd1;
                  ep_next = rq_src_ep;
                  // frames for another cluster or endpoint are consumed silently
                  reply_en_next = rq_unicast && ctrl_en_reg && rq_cluster == `FBC_CLUSTER
                                  && rq_dst_ep == `FBC_MGMT_EP;
               end
               if (hidx_reg == `FBC_HDR_BYTES - 4'd1 && st_reg == FBC_HDR) begin
                  base_next = AW'(int'(h.block_index) * BLOCK_SIZE
                                  + int'(h.byte_offset_in_block));
                  ea_next = AW'(int'(h.block_index) * BLOCK_SIZE);
                  eend_next = AW'((int'(h.block_index) + 1) * BLOCK_SIZE - 1);
                  if (!reply_en_reg || (h.command_code != `FBC_CMD_ERASE
                      && h.command_code != `FBC_CMD_WRITE
                      && h.command_code != `FBC_CMD_ETW)) begin
                     reply_en_next = 1'b0;
                     st_next = rq_last ? FBC_IDLE : FBC_DRAIN;
                  end else if (h.command_code == `FBC_CMD_ERASE) begin
                     if (h.byte_count == 16'h0000) begin
                        ea_next = '0;
                        eend_next = AW'(TOTAL - 1);
                        st_next = FBC_ERASE;
                     end else if (int'(h.block_index) >= NUM_BLOCKS) begin
                        status_next = `FBC_ERR_BLOCK;
                        st_next = rq_last ? FBC_REPLY : FBC_DRAIN;
                     end else begin
                        st_next = FBC_ERASE;
                     end
                  end else if (int'(h.block_index) >= NUM_BLOCKS) begin
                     status_next = `FBC_ERR_BLOCK;
                     st_next = rq_last ? FBC_REPLY : FBC_DRAIN;
                  end else if (int'(h.byte_offset_in_block) + int'(h.byte_count)
                               > BLOCK_SIZE) begin
                     status_next = `FBC_ERR_BOUNDS;
                     st_next = rq_last ? FBC_REPLY : FBC_DRAIN;
                  end else if (int'(h.byte_count) + 8 > MAX_PAYLOAD) begin
                     status_next = `FBC_ERR_PAYLOAD;
                     st_next = rq_last ? FBC_REPLY : FBC_DRAIN;
                  end else begin
                     st_next = (h.command_code == `FBC_CMD_ETW) ? FBC_ERASE
                                                                : FBC_DATA;
                  end
               end else if (rq_last) begin
                  // short frame: no header, nothing to answer
                  st_next = FBC_IDLE;
               end
            end
         end
         FBC_ERASE: begin
            mem_we = 1'b1;
            ea_next = ea_reg + AW'(1);
            if (ea_reg == eend_reg) begin
               if (hdr_reg.command_code == `FBC_CMD_ETW) begin
                  st_next = FBC_DATA;
               end else begin
                  st_next = last_seen_reg ? FBC_REPLY : FBC_DRAIN;
               end
            end
         end
         FBC_DATA: begin
            if (last_seen_reg) begin
               st_next = FBC_REPLY;
            end else if (take) begin
               // bytes beyond byte_count are dropped, never written past the block
               if (wcnt_reg < hdr_reg.byte_count) begin
                  mem_we = 1'b1;
                  mem_waddr = base_reg + AW'(wcnt_reg);
                  mem_wdata = rq_data;
               end
               wcnt_next = wcnt_reg + 16'h0001;
               last_seen_next = rq_last;
               if (rq_last) begin
                  st_next = FBC_REPLY;
               end
            end
         end
         FBC_DRAIN: begin
            if (last_seen_reg || (take && rq_last)) begin
               last_seen_next = 1'b1;
               st_next = reply_en_reg ? FBC_REPLY : FBC_IDLE;
            end
         end
         FBC_REPLY: begin
            if (!reply_en_reg) begin
               st_next = FBC_IDLE;
            end else if (rp_reg.valid && rp_ready && rp_reg.last) begin
               rp_next.valid = 1'b0;
               count_next = count_reg + 32'h00000001;
               st_next = FBC_IDLE;
            end else if (!rp_reg.valid || rp_ready) begin
               rp_pos_next = rp_reg.valid ? rp_pos_reg + 3'd1 : 3'd0;
               rp_next.valid = 1'b1;
               rp_next.data = reply_byte(hdr_reg, status_reg, rp_pos_next);
               rp_next.last = rp_pos_next == 3'd7;
            end
         end
         default: st_next = FBC_IDLE;
      endcase
      rq_ready_next = (st_next == FBC_IDLE || st_next == FBC_HDR || st_next == FBC_DATA
                       || st_next == FBC_DRAIN) && !last_seen_next;
      if (st_next == FBC_IDLE) begin
         rq_ready_next = 1'b1;
         last_seen_next = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= FBC_IDLE;
         hdr_reg <= '0;
         hidx_reg <= 4'h0;
         reply_en_reg <= 1'b0;
         ep_reg <= 8'h00;
         status_reg <= `FBC_OK;
         last_seen_reg <= 1'b0;
         ea_reg <= '0;
         eend_reg <= '0;
         base_reg <= '0;
         wcnt_reg <= 16'h0000;
         rp_pos_reg <= 3'h0;
         rp_reg <= '0;
         rq_ready <= 1'b1;
         count_reg <= 32'h00000000;
      end else begin
         st_reg <= st_next;
         hdr_reg <= hdr_next;
         hidx_reg <= hidx_next;
         reply_en_reg <= reply_en_next;
         ep_reg <= ep_next;
         status_reg <= status_next;
         last_seen_reg <= last_seen_next;
         ea_reg <= ea_next;
         eend_reg <= eend_next;
         base_reg <= base_next;
         wcnt_reg <= wcnt_next;
         rp_pos_reg <= rp_pos_next;
         rp_reg <= rp_next;
         rq_ready <= rq_ready_next;
         count_reg <= count_next;
      end
   end
   assign rp_valid = rp_reg.valid;
   assign rp_data = rp_reg.data;
   assign rp_last = rp_reg.last;
   assign rp_dst_ep = ep_reg;

   fbc_store #(.AW(AW), .DEPTH(TOTAL)) u_store (
      .pclk(pclk),
      .we(mem_we),
      .waddr(mem_waddr),
      .wdata(mem_wdata),
      .raddr(peek_reg),
      .rdata(peek_rdata)
   );

   // ****************************************
   // apb slave, no wait state: the answer is registered in the setup phase
   // ****************************************
   function automatic logic reg_hit(input logic [7:0] a);
      reg_hit = a == `FBC_CTRL_OFS || a == `FBC_STAT_OFS || a == `FBC_COUNT_OFS
                || a == `FBC_PEEKA_OFS || a == `FBC_PEEKD_OFS;
   endfunction

   always_comb begin
      ctrl_en_next = ctrl_en_reg;
      peek_next = peek_reg;
      prdata_next = prdata;
      pready_next = psel && !penable;
      pslverr_next = psel && !penable && !reg_hit(paddr);
      if (psel && !penable && !pwrite) begin
         unique case (paddr)
            `FBC_CTRL_OFS: prdata_next = {31'h0, ctrl_en_reg};
            `FBC_STAT_OFS: prdata_next = {15'h0, st_reg != FBC_IDLE, status_reg,
                                          hdr_reg.command_code};
            `FBC_COUNT_OFS: prdata_next = count_reg;
            `FBC_PEEKA_OFS: prdata_next = 32'(peek_reg);
            `FBC_PEEKD_OFS: prdata_next = {24'h0, peek_rdata};
            default: prdata_next = 32'h00000000;
         endcase
      end
      if (psel && penable && pready && pwrite) begin
         if (paddr == `FBC_CTRL_OFS) begin
            ctrl_en_next = pwdata[`FBC_CTRL_EN_BIT];
         end
         if (paddr == `FBC_PEEKA_OFS) begin
            peek_next = pwdata[AW-1:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_en_reg <= `FBC_CTRL_RST;
         peek_reg <= '0;
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         ctrl_en_reg <= ctrl_en_next;
         peek_reg <= peek_next;
         prdata <= prdata_next;
         pready <= pready_next;
         pslverr <= pslverr_next;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   erase_ones_a: assert property (st_reg == FBC_ERASE |-> mem_we && mem_wdata == 8'hFF)
      else $error("erase did not write ones");
   erase_all_a: assert property (
      $rose(st_reg == FBC_ERASE) && hdr_reg.command_code == `FBC_CMD_ERASE
      && hdr_reg.byte_count == 16'h0000 |-> ea_reg == '0 && eend_reg == AW'(TOTAL - 1))
      else $error("whole area erase range wrong");
   etw_order_a: assert property (
      $rose(st_reg == FBC_DATA) && hdr_reg.command_code == `FBC_CMD_ETW
      |-> $past(st_reg) == FBC_ERASE)
      else $error("write began before erase");
   reply_code_a: assert property (
      rp_valid && rp_pos_reg == 3'd0 |-> rp_data == (hdr_reg.command_code | 8'h80))
      else $error("reply code wrong");
   status_echo_a: assert property (
      rp_valid && rp_pos_reg == 3'd1 |-> rp_data == status_reg)
      else $error("result code not sent");
   field_echo_a: assert property (
      rp_valid && rp_pos_reg == 3'd2 |-> rp_data == hdr_reg.block_index[15:8])
      else $error("block index not echoed");
   zero_count_a: assert property (
      rp_valid && rp_pos_reg == 3'd7 |-> rp_data == 8'h00 && rp_last && $past(rp_data) == 8'h00)
      else $error("reply count not zero");
   no_broadcast_a: assert property (!reply_en_reg |-> !rp_valid)
      else $error("reply for broadcast");
   // address rebuilt from the header fields, not from the base register it checks
   write_addr_a: assert property (
      st_reg == FBC_DATA && mem_we |-> mem_waddr == AW'(int'(hdr_reg.block_index) * BLOCK_SIZE
      + int'(hdr_reg.byte_offset_in_block) + int'(wcnt_reg)))
      else $error("write address wrong");
   err_nowrite_a: assert property (status_reg != 8'h00 |-> !mem_we)
      else $error("storage changed on error");
   bounds_a: assert property (
      st_reg == FBC_DATA && mem_we |-> int'(wcnt_reg) + int'(hdr_reg.byte_offset_in_block)
      < BLOCK_SIZE)
      else $error("write past block end");
   erase_cov: cover property (st_reg == FBC_ERASE && hdr_reg.command_code == 8'h01);
   etw_cov: cover property ($rose(st_reg == FBC_DATA) && hdr_reg.command_code == 8'h03);
   err_cov: cover property (rp_valid && rp_pos_reg == 3'd1 && rp_data != 8'h00);
   reply_cov: cover property (rp_valid && rp_ready && rp_last);
endmodule // fbc_cmd

// [common/fbc_regs.svh]
// constants of the block storage command handler: codes, offsets, reset values
// assumes inclusion by the design and bench files only
`ifndef FBC_REGS_SVH
`define FBC_REGS_SVH
// ****************************************
// command and reply codes, cluster, endpoint, header length, erased value
// ****************************************
`define FBC_CMD_ERASE 8'h01
`define FBC_CMD_WRITE 8'h02
`define FBC_CMD_ETW 8'h03
`define FBC_REPLY_BIT 8'h80
`define FBC_CLUSTER 16'h0023
`define FBC_MGMT_EP 8'hE6
`define FBC_HDR_BYTES 4'h8
`define FBC_ERASED 8'hFF
// ****************************************
// result codes, nonzero means failure
// ****************************************
`define FBC_OK 8'h00
`define FBC_ERR_BLOCK 8'h01
`define FBC_ERR_BOUNDS 8'h02
`define FBC_ERR_PAYLOAD 8'h03
// ****************************************
// apb register map
// ****************************************
`define FBC_CTRL_OFS 8'h00
`define FBC_STAT_OFS 8'h04
`define FBC_COUNT_OFS 8'h08
`define FBC_PEEKA_OFS 8'h0C
`define FBC_PEEKD_OFS 8'h10
`define FBC_CTRL_EN_BIT 0
`define FBC_CTRL_RST 1'b1
`endif

// [common/fbc_pkg.sv]
// types of the block storage command handler
// assumes fbc_regs.svh sits on the include path
package fbc_pkg;
   // ****************************************
   // request header, byte 0 in the top bits
   // ****************************************
   typedef struct packed {
      logic [7:0] command_code;
      logic [7:0] option_byte;
      logic [15:0] block_index;
      logic [15:0] byte_offset_in_block;
      logic [15:0] byte_count;
   } fbc_hdr_t;
   typedef struct packed {
      logic valid;
      logic [7:0] data;
      logic last;
   } fbc_beat_t;
   typedef enum logic [2:0] {
      FBC_IDLE = 3'b000,
      FBC_HDR = 3'b001,
      FBC_ERASE = 3'b010,
      FBC_DATA = 3'b011,
      FBC_DRAIN = 3'b100,
      FBC_REPLY = 3'b101
   } fbc_state_t;
endpackage

// [verilog/fbc_store.sv]
// byte-wide storage array of the user storage area
// assumes one writer per cycle; the read port is one cycle late
`timescale 1ns/1ps
module fbc_store #(
   parameter int AW = 16,
   parameter int DEPTH = 60928
) (
   input wire logic pclk,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [7:0] wdata,
   input wire logic [AW-1:0] raddr,
   output logic [7:0] rdata
);
   // no reset on the array: contents stand for non-volatile cells
   logic [7:0] mem [DEPTH];
   always_ff @(posedge pclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule // fbc_store

// [dv/fbc_node.sv]
// requesting node that frames storage commands and collects the replies
// assumes send_frame is called just after a rising edge of pclk
`timescale 1ns/1ps
`include "fbc_regs.svh"
module fbc_node import fbc_pkg::*; (
   input wire logic pclk,
   output logic rq_valid,
   output logic [7:0] rq_data,
   output logic rq_last,
   output logic rq_unicast,
   output logic [7:0] rq_src_ep,
   output logic [7:0] rq_dst_ep,
   output logic [15:0] rq_cluster,
   input wire logic rq_ready,
   input wire logic rp_valid,
   input wire logic [7:0] rp_data,
   input wire logic rp_last,
   input wire logic [7:0] rp_dst_ep,
   output logic rp_ready
);
   // ****************************************
   // request framing and reply capture
   // ****************************************
   logic slow = 1'b0;
   logic [7:0] rsp [$];
   logic [7:0] ep = 8'h00;
   int lastpos = -1;
   initial begin
      rq_valid = 1'b0;
      rq_data = 8'h5A;
      rq_last = 1'b0;
      rq_unicast = 1'b0;
      rq_src_ep = 8'h00;
      rq_dst_ep = 8'h00;
      rq_cluster = 16'h0000;
      rp_ready = 1'b1;
   end
   task automatic send_frame(input fbc_hdr_t h, input logic [7:0] d [$], input logic uni,
                             input logic [7:0] src, input logic [15:0] cl);
      logic [7:0] b [$];
      b = {h.command_code, 8'h00, h.block_index[15:8], h.block_index[7:0],
           h.byte_offset_in_block[15:8], h.byte_offset_in_block[7:0],
           h.byte_count[15:8], h.byte_count[7:0]};
      b = {b, d};
      rq_unicast <= uni;
      rq_src_ep <= src;
      rq_dst_ep <= (cl == `FBC_CLUSTER) ? `FBC_MGMT_EP : 8'h00;
      rq_cluster <= cl;
      foreach (b[i]) begin
         rq_valid <= 1'b1;
         rq_data <= b[i];
         rq_last <= (i == b.size() - 1);
         @(posedge pclk);
         while (rq_ready !== 1'b1) @(posedge pclk);
      end
      // released lines show the inverse so a stale byte never passes as valid
      rq_valid <= 1'b0;
      rq_data <= ~rq_data;
      rq_last <= 1'b0;
      rq_src_ep <= ~rq_src_ep;
   endtask
   always @(posedge pclk) begin
      if (rp_valid === 1'b1 && rp_ready === 1'b1) begin
         if (rp_last === 1'b1) lastpos = rsp.size();
         rsp.push_back(rp_data);
         ep = rp_dst_ep;
      end
      rp_ready <= slow ? 1'($urandom) : 1'b1;
   end
endmodule // fbc_node

// [dv/testbench.sv]
// self-checking bench of the storage command handler
// assumes small block sizes so that whole-area erases stay short
`timescale 1ns/1ps
`include "fbc_regs.svh"
module testbench import fbc_pkg::*;;
   // ****************************************
   // signals, design and partner
   // ****************************************
   localparam int NB = 4;
   localparam int BS = 32;
   localparam int MP = 32;
   localparam logic [15:0] CL = `FBC_CLUSTER;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, en;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic rq_valid, rq_last, rq_unicast, rq_ready, rp_valid, rp_last, rp_ready;
   logic [7:0] rq_data, rq_src_ep, rq_dst_ep, rp_data, rp_dst_ep;
   logic [15:0] rq_cluster;
   logic [7:0] mem [NB*BS];
   int failures = 0;
   int total_checks = 0;
   int nrep = 0;
   fbc_cmd #(.NUM_BLOCKS(NB), .BLOCK_SIZE(BS), .MAX_PAYLOAD(MP)) u_fbc_cmd (.pclk, .presetn,
      .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rq_valid,
      .rq_data, .rq_last, .rq_unicast, .rq_src_ep, .rq_dst_ep, .rq_cluster, .rq_ready,
      .rp_valid, .rp_data, .rp_last, .rp_dst_ep, .rp_ready);
   fbc_node u_fbc_node (.pclk, .rq_valid, .rq_data, .rq_last, .rq_unicast, .rq_src_ep,
      .rq_dst_ep, .rq_cluster, .rq_ready, .rp_valid, .rp_data, .rp_last, .rp_dst_ep, .rp_ready);
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   // ****************************************
   // shared tasks
   // ****************************************
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rdv, output logic err);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      // no limit here: only the watchdog may end a stalled transfer
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rdv = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic chk_mem;
      for (int i = 0; i < NB * BS; i++) begin
         apb(1'b1, `FBC_PEEKA_OFS, 32'(i), rd, e);
         apb(1'b0, `FBC_PEEKD_OFS, 32'h0, rd, e);
         chk("storage byte", rd[7:0], mem[i]);
      end
   endtask
   task automatic op(input logic [7:0] c, input int b, input int o, input int n,
                     input logic uni, input logic [15:0] cl);
      fbc_hdr_t h;
      logic [7:0] d [$];
      logic [7:0] st, src;
      logic rep;
      h = '{c, 8'h00, 16'(b), 16'(o), 16'(n)};
      for (int i = 0; i < n && c != `FBC_CMD_ERASE; i++) d.push_back(8'($urandom));
      src = 8'($urandom);
      st = ((c != `FBC_CMD_ERASE || n != 0) && b >= NB) ? `FBC_ERR_BLOCK :
           (o + n > BS) ? `FBC_ERR_BOUNDS :
           (c != `FBC_CMD_ERASE && n + 8 > MP) ? `FBC_ERR_PAYLOAD : `FBC_OK;
      rep = uni && cl == CL && en;
      if (rep && st == `FBC_OK) begin
         for (int i = 0; i < NB * BS; i++)
            if ((c != `FBC_CMD_WRITE && i / BS == b) || (c == `FBC_CMD_ERASE && n == 0))
               mem[i] = `FBC_ERASED;
         foreach (d[i]) mem[b * BS + o + i] = d[i];
      end
      u_fbc_node.send_frame(h, d, uni, src, cl);
      for (int w = 0; w < 2000 && u_fbc_node.rsp.size() < 8; w++) @(posedge pclk);
      if (rep) begin
         nrep++;
         chk("reply code", u_fbc_node.rsp[0], c | `FBC_REPLY_BIT);
         chk("result code", u_fbc_node.rsp[1], st);
         chk("block echo", {u_fbc_node.rsp[2], u_fbc_node.rsp[3]}, h.block_index);
         chk("offset echo", {u_fbc_node.rsp[4], u_fbc_node.rsp[5]}, 16'(o));
         chk("reply count", {u_fbc_node.rsp[6], u_fbc_node.rsp[7]}, 16'h0);
         chk("reply length", 32'(u_fbc_node.lastpos), 32'h7);
         chk("reply endpoint", u_fbc_node.ep, src);
      end
      else chk("silent frame", 32'(u_fbc_node.rsp.size()), 32'h0);
      apb(1'b0, `FBC_STAT_OFS, 32'h0, rd, e);
      chk("status reg", rd, {16'h0, rep ? st : `FBC_OK, c});
      u_fbc_node.rsp.delete();
      u_fbc_node.lastpos = -1;
      chk_mem();
      $display("test op %h block %0d offset %0d count %0d done", c, b, o, n);
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // ****************************************
   // test sequence
   // ****************************************
   initial begin
      int o, n, lim;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      en = 1'b1;
      void'($urandom(32'h4419507E));
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, `FBC_CTRL_OFS, 32'h0, rd, e);
      chk("ctrl reset", rd[0], `FBC_CTRL_RST);
      chk("mapped error", e, 1'b0);
      apb(1'b0, `FBC_COUNT_OFS, 32'h0, rd, e);
      chk("count reset", rd, 32'h0);
      apb(1'b0, 8'h40, 32'h0, rd, e);
      chk("unmapped error", e, 1'b1);
      chk("unmapped data", rd, 32'h0);
      $display("test registers done");
      op(`FBC_CMD_ERASE, 0, 0, 0, 1'b1, CL);
      op(`FBC_CMD_WRITE, 2, 5, 9, 1'b1, CL);
      op(`FBC_CMD_WRITE, 3, BS - 1, 1, 1'b1, CL);
      op(`FBC_CMD_ERASE, 2, 0, BS, 1'b1, CL);
      op(`FBC_CMD_WRITE, 1, 0, MP - 8, 1'b1, CL);
      op(`FBC_CMD_ETW, 1, 3, 4, 1'b1, CL);
      op(`FBC_CMD_WRITE, 0, 20, 13, 1'b1, CL);
      op(`FBC_CMD_ETW, NB, 0, 1, 1'b1, CL);
      op(`FBC_CMD_WRITE, 0, 0, MP - 7, 1'b1, CL);
      op(`FBC_CMD_ERASE, NB, 0, BS, 1'b1, CL);
      op(`FBC_CMD_WRITE, 0, 0, 4, 1'b0, CL);
      op(`FBC_CMD_WRITE, 0, 0, 4, 1'b1, 16'h0024);
      en = 1'b0;
      apb(1'b1, `FBC_CTRL_OFS, 32'h0, rd, e);
      op(`FBC_CMD_WRITE, 0, 0, 4, 1'b1, CL);
      en = 1'b1;
      apb(1'b1, `FBC_CTRL_OFS, 32'h1, rd, e);
      // reply sink stalls at random from here on
      u_fbc_node.slow = 1'b1;
      repeat (6) begin
         o = $urandom_range(BS - 1, 0);
         lim = (BS - o < MP - 8) ? BS - o : MP - 8;
         n = $urandom_range(lim, 1);
         op(`FBC_CMD_WRITE + 8'($urandom_range(1, 0)), $urandom_range(NB - 1, 0), o, n,
            1'b1, CL);
      end
      apb(1'b0, `FBC_COUNT_OFS, 32'h0, rd, e);
      chk("replies sent", rd, 32'(nrep));
      print_verdict();
   end
   initial begin
      repeat (40000) @(posedge pclk);
      failures++;
      print_verdict();
   end
endmodule // testbench
